/* File: rtl/cobt_consts.svh */
// Register offsets, field positions, reset values and codes of the object and bit timing block
`ifndef COBT_CONSTS_SVH
`define COBT_CONSTS_SVH

`define COBT_OFS_FC_CTRL 8'h00
`define COBT_OFS_FC_VALUE 8'h04
`define COBT_OFS_OBJ_SEL 8'h08
`define COBT_OFS_OBJ_CTRL 8'h0c
`define COBT_OFS_OBJ_DATA 8'h10
`define COBT_OFS_TX_STAT 8'h14
`define COBT_OFS_TX_DATA 8'h18

`define COBT_FC_CTRL_RST 5'h00
`define COBT_FC_MODE_MEASURE 2'h2
`define COBT_SEL_DOM_TO_REC 3'h1
`define COBT_SEL_TX_DOM_LOOP 3'h2
`define COBT_SEL_TX_REC_LOOP 3'h3
`define COBT_SEL_SP_TO_SYNC 3'h4

`define COBT_CTRL_CLR_LSB 0
`define COBT_CTRL_SET_LSB 16
`define COBT_TX_STAT_IDX_LSB 8

`endif

/* File: rtl/cobt_obj_mem.sv */
// Message object payload store with registered read data
`timescale 1ns/10ps
module cobt_obj_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32,
    localparam int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rd_data_q;

    // No reset on the array; contents are undefined until written
    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        if (rd_en_in) begin
            rd_data_q <= mem_q[rd_addr_in];
        end
    end

    assign rd_data_out = rd_data_q;
endmodule // cobt_obj_mem

/* File: rtl/cobt_pkg.sv */
// Types shared by the object and bit timing block
package cobt_pkg;

    // Listed MSB first, so object_valid is bit 0
    typedef struct packed {
        logic single_transfer_mode;
        logic receive_updating_flag;
        logic transmit_request;
        logic transmit_enable_b;
        logic transmit_enable_a;
        logic receive_enable_bit;
        logic receive_pending_flag;
        logic message_lost_flag;
        logic new_data_flag;
        logic object_valid;
    } cobt_obj_ctrl_s;

    typedef struct packed {
        logic [1:0] frame_counter_mode;
        logic [2:0] frame_counter_select;
    } cobt_fc_ctrl_s;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_FILTER,
        TX_COPY,
        TX_BUSY
    } cobt_tx_state_e;

endpackage

/* File: rtl/cobt_top.sv */
// CAN node frame counter bit timing measurement and message object handling
// Operation
// R1 - Mode 10 selects bit timing measurement
// R2 - 001: store cycles dominant to recessive
// R3 - 010: store own dominant edge loop delay
// R4 - 011: store own recessive edge loop delay
// R5 - 100: store sample point to sync edge
// R6 - Clearing one valid flag affects only it
// R7 - All object kinds share storage rules
// R8 - Storage sets status flags, raises receive interrupt
// R9 - Transmit copy clears object new data flag
// R10 - Pending requests transmit on idle bus
// R11 - Single transfer clears valid after transfer
// R12 - Software disables via enables, not valid
// R13 - Lost winner request restarts filtering
// R14 - Setting any transmit request restarts filtering
// R15 - Rewriting set request or enable restarts filtering
// R16 - Receive updating flag held during storage
// R17 - Single transfer clears valid after rx/tx
// R18 - Filtering needs valid, request, both enables
`timescale 1ns/10ps
`include "cobt_consts.svh"
module cobt_top #(
    parameter int NUM_OBJ = 8,
    parameter int DATA_W = 32,
    parameter int CNT_W = 16,
    localparam int IDX_W = $clog2(NUM_OBJ)
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic can_rx_in,
    input wire logic tx_bit_in,
    output logic can_tx_out,
    input wire logic sample_point_in,
    input wire logic sync_edge_in,
    input wire logic rx_store_valid_in,
    input wire logic [IDX_W-1:0] rx_store_obj_in,
    input wire logic [DATA_W-1:0] rx_store_data_in,
    input wire logic tx_active_in,
    input wire logic tx_done_in,
    output logic tx_buf_valid_out,
    output logic [IDX_W-1:0] tx_buf_obj_out,
    output logic [DATA_W-1:0] tx_buf_data_out,
    output logic obj_rx_irq_out,
    output logic [IDX_W-1:0] obj_rx_irq_idx_out
);
    generate
        if (NUM_OBJ < 2 || NUM_OBJ > 256 || DATA_W < 1 || DATA_W > 32 || CNT_W < 2 || CNT_W > 32)
        begin : g_bad_param
            $error("cobt_top: parameter out of range");
        end
    endgenerate

    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
    endfunction

    // Bit timing measurement state
    logic rx_meta_q, rx_sync_q, rx_prev_q, can_tx_q;
    logic wait_dom_q, wait_dom_d, wait_rec_q, wait_rec_d;
    logic [CNT_W-1:0] cnt_dom_q, cnt_dom_d, cnt_tx_q, cnt_tx_d, cnt_sp_q, cnt_sp_d;
    logic [CNT_W-1:0] fc_value_q, fc_value_d;
    cobt_pkg::cobt_fc_ctrl_s fc_ctrl_q, fc_ctrl_d;
    logic rx_fall, rx_rise, tx_fall, tx_rise;

    always_comb begin
        rx_fall = rx_prev_q & ~rx_sync_q;
        rx_rise = ~rx_prev_q & rx_sync_q;
        tx_fall = can_tx_q & ~tx_bit_in;
        tx_rise = ~can_tx_q & tx_bit_in;
        // Counters restart at one so the stored figure equals the edge-to-edge cycles
        cnt_dom_d = rx_fall ? CNT_ONE : sat_inc(cnt_dom_q);
        cnt_tx_d = (tx_fall | tx_rise) ? CNT_ONE : sat_inc(cnt_tx_q);
        cnt_sp_d = sample_point_in ? CNT_ONE : sat_inc(cnt_sp_q);
        wait_dom_d = tx_fall | (wait_dom_q & ~rx_fall & ~tx_rise);
        wait_rec_d = tx_rise | (wait_rec_q & ~rx_rise & ~tx_fall);
        fc_value_d = fc_value_q;
        if (fc_ctrl_q.frame_counter_mode == `COBT_FC_MODE_MEASURE) begin // R1
            unique case (fc_ctrl_q.frame_counter_select)
                `COBT_SEL_DOM_TO_REC: begin
                    if (rx_rise) fc_value_d = cnt_dom_q; // R2
                end
                `COBT_SEL_TX_DOM_LOOP: begin
                    if (rx_fall && wait_dom_q) fc_value_d = cnt_tx_q; // R3
                end
                `COBT_SEL_TX_REC_LOOP: begin
                    if (rx_rise && wait_rec_q) fc_value_d = cnt_tx_q; // R4
                end
                `COBT_SEL_SP_TO_SYNC: begin
                    if (rx_fall && sync_edge_in) fc_value_d = cnt_sp_q; // R5
                end
                default: fc_value_d = fc_value_q;
            endcase
        end
    end

    // Pin input: rx_meta_q is read only by rx_sync_q
    always_ff @(posedge clk_sys_in) begin
        rx_meta_q <= can_rx_in;
        rx_sync_q <= rx_meta_q;
        if (!reset_n_in) begin
            rx_prev_q <= 1'b1;
            can_tx_q <= 1'b1;
            wait_dom_q <= 1'b0;
            wait_rec_q <= 1'b0;
            cnt_dom_q <= '0;
            cnt_tx_q <= '0;
            cnt_sp_q <= '0;
            fc_value_q <= '0;
        end else begin
            rx_prev_q <= rx_sync_q;
            can_tx_q <= tx_bit_in;
            wait_dom_q <= wait_dom_d;
            wait_rec_q <= wait_rec_d;
            cnt_dom_q <= cnt_dom_d;
            cnt_tx_q <= cnt_tx_d;
            cnt_sp_q <= cnt_sp_d;
            fc_value_q <= fc_value_d;
        end
    end

    // Objects, storage, transmit filtering and APB
    cobt_pkg::cobt_obj_ctrl_s ctrl_q [NUM_OBJ];
    cobt_pkg::cobt_obj_ctrl_s ctrl_d [NUM_OBJ];
    cobt_pkg::cobt_tx_state_e tx_state_q, tx_state_d;
    logic [IDX_W-1:0] sel_q, sel_d, win_q, win_d, st_idx_q, st_idx_d, first_idx;
    logic [IDX_W-1:0] irq_idx_q, irq_idx_d, mem_wr_addr, mem_rd_addr;
    logic st_busy_q, st_busy_d, irq_q, irq_d, rd_pend_q, rd_pend_d;
    logic txbuf_valid_q, txbuf_valid_d, pready_q, pready_d, pslverr_q, pslverr_d;
    logic [DATA_W-1:0] txbuf_q, txbuf_d, mem_wr_data, mem_rd_data;
    logic [31:0] prdata_q, prdata_d;
    logic [NUM_OBJ-1:0] elig;
    logic any_elig, rx_ok, access, sw_ctrl_wr, retrigger, mem_wr, mem_rd;
    cobt_pkg::cobt_obj_ctrl_s clr_mask, set_mask;

    cobt_obj_mem #(
        .DEPTH(NUM_OBJ),
        .WIDTH(DATA_W)
    ) u_mem (
        .clk_sys_in(clk_sys_in),
        .wr_en_in(mem_wr),
        .wr_addr_in(mem_wr_addr),
        .wr_data_in(mem_wr_data),
        .rd_en_in(mem_rd),
        .rd_addr_in(mem_rd_addr),
        .rd_data_out(mem_rd_data)
    );

    always_comb begin
        for (int i = 0; i < NUM_OBJ; i++) begin
            elig[i] = ctrl_q[i].object_valid & ctrl_q[i].transmit_request
                    & ctrl_q[i].transmit_enable_a & ctrl_q[i].transmit_enable_b; // R18
        end
        any_elig = |elig;
        first_idx = '0;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (elig[i]) first_idx = IDX_W'(i);
        end
        clr_mask = cobt_pkg::cobt_obj_ctrl_s'(pwdata_in[`COBT_CTRL_CLR_LSB +: 10]);
        set_mask = cobt_pkg::cobt_obj_ctrl_s'(pwdata_in[`COBT_CTRL_SET_LSB +: 10]);
        // One storage path whatever kind of object the node targets
        rx_ok = rx_store_valid_in & ctrl_q[rx_store_obj_in].object_valid
              & ctrl_q[rx_store_obj_in].receive_enable_bit; // R7
        access = psel_in & penable_in & ~pready_q;

        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        fc_ctrl_d = fc_ctrl_q;
        sel_d = sel_q;
        rd_pend_d = rd_pend_q;
        sw_ctrl_wr = 1'b0;
        mem_wr = rx_ok;
        mem_wr_addr = rx_store_obj_in;
        mem_wr_data = rx_store_data_in;
        mem_rd = 1'b0;
        mem_rd_addr = first_idx;
        if (access && pwrite_in) begin
            pready_d = 1'b1;
            unique case (paddr_in)
                `COBT_OFS_FC_CTRL: fc_ctrl_d = cobt_pkg::cobt_fc_ctrl_s'(pwdata_in[4:0]);
                `COBT_OFS_OBJ_SEL: sel_d = pwdata_in[IDX_W-1:0];
                `COBT_OFS_OBJ_CTRL: sw_ctrl_wr = 1'b1;
                `COBT_OFS_OBJ_DATA: begin
                    // Frame storage owns the write port; software waits a cycle
                    if (rx_ok) begin
                        pready_d = 1'b0;
                    end else begin
                        mem_wr = 1'b1;
                        mem_wr_addr = sel_q;
                        mem_wr_data = pwdata_in[DATA_W-1:0];
                    end
                end
                `COBT_OFS_FC_VALUE, `COBT_OFS_TX_STAT, `COBT_OFS_TX_DATA: pready_d = 1'b1;
                default: pslverr_d = 1'b1;
            endcase
        end else if (access) begin
            pready_d = 1'b1;
            prdata_d = '0;
            unique case (paddr_in)
                `COBT_OFS_FC_CTRL: prdata_d[4:0] = fc_ctrl_q;
                `COBT_OFS_FC_VALUE: prdata_d[CNT_W-1:0] = fc_value_q;
                `COBT_OFS_OBJ_SEL: prdata_d[IDX_W-1:0] = sel_q;
                `COBT_OFS_OBJ_CTRL: prdata_d[9:0] = ctrl_q[sel_q];
                `COBT_OFS_TX_STAT: begin
                    prdata_d[0] = txbuf_valid_q;
                    prdata_d[`COBT_TX_STAT_IDX_LSB +: IDX_W] = win_q;
                end
                `COBT_OFS_TX_DATA: prdata_d[DATA_W-1:0] = txbuf_q;
                `COBT_OFS_OBJ_DATA: begin
                    if (rd_pend_q) begin
                        prdata_d[DATA_W-1:0] = mem_rd_data;
                        rd_pend_d = 1'b0;
                    end else begin
                        pready_d = 1'b0;
                        prdata_d = prdata_q;
                        if (tx_state_q != cobt_pkg::TX_FILTER) begin
                            mem_rd = 1'b1;
                            mem_rd_addr = sel_q;
                            rd_pend_d = 1'b1;
                        end
                    end
                end
                default: pslverr_d = 1'b1;
            endcase
        end

        // Writing a one to request or either enable, set or not, restarts filtering
        retrigger = sw_ctrl_wr & (set_mask.transmit_request | set_mask.transmit_enable_a
                  | set_mask.transmit_enable_b); // R14 R15

        // Software updates touch only the selected object; set wins over clear
        for (int i = 0; i < NUM_OBJ; i++) begin
            ctrl_d[i] = ctrl_q[i];
            if (sw_ctrl_wr && sel_q == IDX_W'(i)) begin // R6
                ctrl_d[i] = (ctrl_q[i] & ~clr_mask) | set_mask;
                ctrl_d[i].receive_updating_flag = ctrl_q[i].receive_updating_flag;
            end
        end

        tx_state_d = tx_state_q;
        win_d = win_q;
        txbuf_d = txbuf_q;
        txbuf_valid_d = txbuf_valid_q;
        unique case (tx_state_q)
            cobt_pkg::TX_IDLE: begin
                if (any_elig) tx_state_d = cobt_pkg::TX_FILTER; // R10
            end
            cobt_pkg::TX_FILTER: begin
                if (any_elig) begin
                    win_d = first_idx;
                    mem_rd = 1'b1;
                    mem_rd_addr = first_idx;
                    tx_state_d = cobt_pkg::TX_COPY;
                end else begin
                    tx_state_d = cobt_pkg::TX_IDLE;
                end
            end
            cobt_pkg::TX_COPY: begin
                // The winner's own flags and retrigger decide; a write setting request or an enable on any selected object aborts the copy
                if (elig[win_q] && !retrigger) begin // R6
                    txbuf_d = mem_rd_data; // R9
                    txbuf_valid_d = 1'b1;
                    ctrl_d[win_q].new_data_flag = 1'b0; // R9
                    tx_state_d = cobt_pkg::TX_BUSY;
                end else begin
                    tx_state_d = cobt_pkg::TX_FILTER; // R13
                end
            end
            cobt_pkg::TX_BUSY: begin
                if (tx_done_in) begin
                    txbuf_valid_d = 1'b0;
                    ctrl_d[win_q].transmit_request = 1'b0;
                    if (ctrl_q[win_q].single_transfer_mode) begin
                        ctrl_d[win_q].object_valid = 1'b0; // R11 R17
                    end
                    tx_state_d = cobt_pkg::TX_IDLE; // R10
                end else if (!tx_active_in && (!elig[win_q] || retrigger)) begin
                    txbuf_valid_d = 1'b0;
                    tx_state_d = cobt_pkg::TX_FILTER; // R13 R14 R15
                end
            end
        endcase

        // Two-cycle storage: flag up while writing, status on completion
        st_busy_d = rx_ok;
        st_idx_d = rx_store_obj_in;
        irq_d = st_busy_q;
        irq_idx_d = st_idx_q;
        if (rx_ok) begin
            ctrl_d[rx_store_obj_in].receive_updating_flag = 1'b1; // R16
        end
        if (st_busy_q) begin
            ctrl_d[st_idx_q].receive_updating_flag = 1'b0; // R16
            ctrl_d[st_idx_q].message_lost_flag = ctrl_q[st_idx_q].new_data_flag
                | ctrl_d[st_idx_q].message_lost_flag; // R8
            ctrl_d[st_idx_q].new_data_flag = 1'b1; // R8
            ctrl_d[st_idx_q].receive_pending_flag = 1'b1; // R8
            if (ctrl_q[st_idx_q].single_transfer_mode) begin
                ctrl_d[st_idx_q].object_valid = 1'b0; // R11 R17
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_OBJ; i++) ctrl_q[i] <= '0;
            fc_ctrl_q <= `COBT_FC_CTRL_RST;
            tx_state_q <= cobt_pkg::TX_IDLE;
            sel_q <= '0;
            win_q <= '0;
            st_idx_q <= '0;
            irq_idx_q <= '0;
            st_busy_q <= 1'b0;
            irq_q <= 1'b0;
            rd_pend_q <= 1'b0;
            txbuf_valid_q <= 1'b0;
            txbuf_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            for (int i = 0; i < NUM_OBJ; i++) ctrl_q[i] <= ctrl_d[i];
            fc_ctrl_q <= fc_ctrl_d;
            tx_state_q <= tx_state_d;
            sel_q <= sel_d;
            win_q <= win_d;
            st_idx_q <= st_idx_d;
            irq_idx_q <= irq_idx_d;
            st_busy_q <= st_busy_d;
            irq_q <= irq_d;
            rd_pend_q <= rd_pend_d;
            txbuf_valid_q <= txbuf_valid_d;
            txbuf_q <= txbuf_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign can_tx_out = can_tx_q;
    assign tx_buf_valid_out = txbuf_valid_q;
    assign tx_buf_obj_out = win_q;
    assign tx_buf_data_out = txbuf_q;
    assign obj_rx_irq_out = irq_q;
    assign obj_rx_irq_idx_out = irq_idx_q;
endmodule // cobt_top

/* File: tb/cobt_can_bus_model.sv */
// Line side model: wired-and bus with a loop delay back to the receive pin
`timescale 1ns/10ps
module cobt_can_bus_model #(
    parameter int LOOP_DLY = 3
) (
    input wire logic clk_sys_in,
    input wire logic can_tx_in,
    input wire logic other_dom_in,
    output logic can_rx_out
);
    logic bus_level;
    logic [LOOP_DLY-1:0] loop_q;
    // Recessive by pull-up unless some node drives dominant
    assign bus_level = can_tx_in & ~other_dom_in;
    initial loop_q = '1;
    // Transceiver and line delay, needs LOOP_DLY of two or more
    always @(posedge clk_sys_in) begin
        loop_q <= {loop_q[LOOP_DLY-2:0], bus_level};
    end
    assign can_rx_out = loop_q[LOOP_DLY-1];
endmodule // cobt_can_bus_model

/* File: tb/cobt_top_asserts.sv */
// Port checker for the object and bit timing block, bound to its top
`timescale 1ns/10ps
`include "cobt_consts.svh"
module cobt_top_asserts #(
    parameter int NUM_OBJ = 8,
    parameter int DATA_W = 32,
    parameter int CNT_W = 16,
    localparam int IDX_W = $clog2(NUM_OBJ)
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic can_rx_in,
    input wire logic tx_bit_in,
    input wire logic can_tx_out,
    input wire logic sample_point_in,
    input wire logic sync_edge_in,
    input wire logic rx_store_valid_in,
    input wire logic [IDX_W-1:0] rx_store_obj_in,
    input wire logic [DATA_W-1:0] rx_store_data_in,
    input wire logic tx_active_in,
    input wire logic tx_done_in,
    input wire logic tx_buf_valid_out,
    input wire logic [IDX_W-1:0] tx_buf_obj_out,
    input wire logic [DATA_W-1:0] tx_buf_data_out,
    input wire logic obj_rx_irq_out,
    input wire logic [IDX_W-1:0] obj_rx_irq_idx_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("pready outside an access phase");
    a_err_unmapped: assert property (pready_out |->
        pslverr_out == (paddr_in > 8'h18 || paddr_in[1:0] != 2'h0))
        else $error("pslverr does not match address map");
    a_reg_ready_next: assert property (psel_in && penable_in && !pready_out &&
        paddr_in != `COBT_OFS_OBJ_DATA |=> pready_out)
        else $error("register access not answered next cycle");
    a_data_ready_bound: assert property (psel_in && !penable_in |=> ##[1:6] pready_out)
        else $error("access not answered in time");
    a_irq_cause: assert property (obj_rx_irq_out |-> $past(rx_store_valid_in, 2))
        else $error("receive interrupt without a store");
    a_irq_index: assert property (obj_rx_irq_out |->
        obj_rx_irq_idx_out == $past(rx_store_obj_in, 2))
        else $error("receive interrupt names wrong object");
    a_done_drops_buf: assert property (tx_done_in && tx_buf_valid_out |=> !tx_buf_valid_out)
        else $error("buffer still valid after done");
    a_buf_owner_stable: assert property (tx_buf_valid_out && $past(tx_buf_valid_out) |->
        $stable(tx_buf_obj_out) && $stable(tx_buf_data_out))
        else $error("buffer changed while held");
    // Reset itself is the cause here, so this one is never disabled
    a_reset_idle: assert property (disable iff (1'b0) !reset_n_in |=>
        can_tx_out && !pready_out && !tx_buf_valid_out && !obj_rx_irq_out)
        else $error("outputs not idle in reset");

    c_irq: cover property (obj_rx_irq_out);
    c_done: cover property (tx_done_in && tx_buf_valid_out);
    c_slverr: cover property (pslverr_out);
endmodule // cobt_top_asserts

bind cobt_top cobt_top_asserts #(.NUM_OBJ(NUM_OBJ), .DATA_W(DATA_W), .CNT_W(CNT_W))
    cobt_top_asserts_inst (.clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .can_rx_in, .tx_bit_in,
    .can_tx_out, .sample_point_in, .sync_edge_in, .rx_store_valid_in, .rx_store_obj_in,
    .rx_store_data_in, .tx_active_in, .tx_done_in, .tx_buf_valid_out, .tx_buf_obj_out,
    .tx_buf_data_out, .obj_rx_irq_out, .obj_rx_irq_idx_out);

/* File: tb/tb_cobt_top.sv */
// Self-checking bench for the object and bit timing block
`timescale 1ns/10ps
`include "cobt_consts.svh"
module tb_cobt_top;
    localparam int LOOP = 3;
    logic clk_sys_in, reset_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rx_store_data_in, tx_buf_data_out, rd;
    logic can_rx_in, tx_bit_in, can_tx_out, sample_point_in, sync_edge_in, other_dom;
    logic rx_store_valid_in, tx_active_in, tx_done_in, tx_buf_valid_out, obj_rx_irq_out, er;
    logic [2:0] rx_store_obj_in, tx_buf_obj_out, obj_rx_irq_idx_out;
    int bad_count, check_count, irq_count;

    cobt_top cobt_top_inst (.clk_sys_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
        .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .can_rx_in,
        .tx_bit_in, .can_tx_out, .sample_point_in, .sync_edge_in, .rx_store_valid_in,
        .rx_store_obj_in, .rx_store_data_in, .tx_active_in, .tx_done_in, .tx_buf_valid_out,
        .tx_buf_obj_out, .tx_buf_data_out, .obj_rx_irq_out, .obj_rx_irq_idx_out);
    cobt_can_bus_model #(.LOOP_DLY(LOOP)) cobt_can_bus_model_inst (.clk_sys_in,
        .can_tx_in(can_tx_out), .other_dom_in(other_dom), .can_rx_out(can_rx_in));

    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // Interrupt is a one-cycle register pulse, so the falling edge sees it settled
    always @(negedge clk_sys_in) begin
        if (obj_rx_irq_out === 1'b1) irq_count++;
    end

    task close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // Answer is taken at the rising edge that samples pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        n = 0;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_sys_in);
        end
        if (n == 20) chk(32'h0, 32'h1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task ctl(input logic [31:0] i, input logic [31:0] d);
        apb(1'b1, `COBT_OFS_OBJ_SEL, i);
        apb(1'b1, `COBT_OFS_OBJ_CTRL, d);
    endtask
    task store(input logic [2:0] i, input logic [31:0] d);
        @(posedge clk_sys_in);
        rx_store_valid_in <= 1'b1;
        rx_store_obj_in <= i;
        rx_store_data_in <= d;
        @(posedge clk_sys_in);
        rx_store_valid_in <= 1'b0;
    endtask
    task dom_pulse(input int n);
        other_dom <= 1'b1;
        idle(n);
        other_dom <= 1'b0;
        idle(12);
    endtask

    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    initial begin
        {reset_n_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {sample_point_in, sync_edge_in, other_dom, rx_store_valid_in, rx_store_obj_in} = '0;
        {rx_store_data_in, tx_active_in, tx_done_in} = '0;
        tx_bit_in = 1'b1;
        bad_count = 0;
        check_count = 0;
        irq_count = 0;
        idle(4);
        reset_n_in <= 1'b1;
        rdc(`COBT_OFS_FC_CTRL, 32'h0);
        rdc(`COBT_OFS_TX_STAT, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, `COBT_OFS_FC_VALUE, 32'h1234);
        rdc(`COBT_OFS_FC_VALUE, 32'h0);
        apb(1'b1, `COBT_OFS_FC_CTRL, 32'h11);
        dom_pulse(9);
        rdc(`COBT_OFS_FC_VALUE, 32'd9);
        apb(1'b1, `COBT_OFS_FC_CTRL, 32'h12);
        tx_bit_in <= 1'b0;
        idle(12);
        rdc(`COBT_OFS_FC_VALUE, LOOP + 3);
        apb(1'b1, `COBT_OFS_FC_CTRL, 32'h13);
        other_dom <= 1'b1;
        tx_bit_in <= 1'b1;
        idle(2);
        other_dom <= 1'b0;
        idle(12);
        rdc(`COBT_OFS_FC_VALUE, LOOP + 4);
        apb(1'b1, `COBT_OFS_FC_CTRL, 32'h14);
        sync_edge_in <= 1'b1;
        sample_point_in <= 1'b1;
        idle(1);
        sample_point_in <= 1'b0;
        idle(4);
        dom_pulse(3);
        sync_edge_in <= 1'b0;
        rdc(`COBT_OFS_FC_VALUE, LOOP + 7);
        apb(1'b1, `COBT_OFS_FC_CTRL, 32'h09);
        dom_pulse(5);
        rdc(`COBT_OFS_FC_VALUE, LOOP + 7);
        // Software clears a valid flag mid-store on purpose; normal use keeps to enables
        ctl(5, 32'h0011_0000);
        ctl(2, 32'h0011_0000);
        apb(1'b1, `COBT_OFS_OBJ_SEL, 32'h5);
        fork
            store(3'h2, 32'ha5a5_0001);
            apb(1'b1, `COBT_OFS_OBJ_CTRL, 32'h1);
        join
        rdc(`COBT_OFS_OBJ_CTRL, 32'h10);
        store(3'h5, 32'h0bad_0005);
        idle(3);
        rdc(`COBT_OFS_OBJ_CTRL, 32'h10);
        apb(1'b1, `COBT_OFS_OBJ_SEL, 32'h2);
        rdc(`COBT_OFS_OBJ_CTRL, 32'h1b);
        rdc(`COBT_OFS_OBJ_DATA, 32'ha5a5_0001);
        store(3'h2, 32'ha5a5_0002);
        idle(3);
        rdc(`COBT_OFS_OBJ_CTRL, 32'h1f);
        ctl(3, 32'h0211_0000);
        store(3'h3, 32'ha5a5_0003);
        idle(3);
        rdc(`COBT_OFS_OBJ_CTRL, 32'h21a);
        chk(irq_count, 32'd3);
        ctl(4, 32'h00a1_0000);
        idle(4);
        rdc(`COBT_OFS_TX_STAT, 32'h0);
        apb(1'b1, `COBT_OFS_OBJ_SEL, 32'h6);
        apb(1'b1, `COBT_OFS_OBJ_DATA, 32'hc0de_0006);
        apb(1'b1, `COBT_OFS_OBJ_CTRL, 32'h00e3_0000);
        idle(4);
        rdc(`COBT_OFS_TX_STAT, 32'h601);
        rdc(`COBT_OFS_OBJ_CTRL, 32'he1);
        rdc(`COBT_OFS_TX_DATA, 32'hc0de_0006);
        chk({29'h0, tx_buf_obj_out}, 32'h6);
        chk(tx_buf_data_out, 32'hc0de_0006);
        ctl(1, 32'h00e1_0000);
        idle(4);
        rdc(`COBT_OFS_TX_STAT, 32'h101);
        apb(1'b1, `COBT_OFS_OBJ_CTRL, 32'h80);
        idle(4);
        rdc(`COBT_OFS_TX_STAT, 32'h601);
        ctl(6, 32'h0002_0000);
        ctl(7, 32'h0080_0000);
        idle(4);
        apb(1'b1, `COBT_OFS_OBJ_SEL, 32'h6);
        rdc(`COBT_OFS_OBJ_CTRL, 32'he1);
        apb(1'b1, `COBT_OFS_OBJ_CTRL, 32'h0002_0000);
        apb(1'b1, `COBT_OFS_OBJ_CTRL, 32'h0020_0000);
        idle(4);
        rdc(`COBT_OFS_OBJ_CTRL, 32'he1);
        apb(1'b1, `COBT_OFS_OBJ_CTRL, 32'h0200_0000);
        idle(4);
        tx_active_in <= 1'b1;
        idle(2);
        tx_done_in <= 1'b1;
        idle(1);
        tx_done_in <= 1'b0;
        tx_active_in <= 1'b0;
        idle(4);
        rdc(`COBT_OFS_OBJ_CTRL, 32'h260);
        rdc(`COBT_OFS_TX_STAT, 32'h600);
        ctl(4, 32'h0040_0000);
        idle(4);
        rdc(`COBT_OFS_TX_STAT, 32'h401);
        close_out();
    end
endmodule // tb_cobt_top
